// ---- shared/rvl_pkg.sv ----
package rvl_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int ROM_DEPTH = 8192;
  localparam int ENC_DEPTH = 32;
  localparam int ENC_SEL_W = 5;
  localparam logic [7:0] ENC_RESET = 8'hFF;
  localparam logic [7:0] ROM_BLANK = 8'hFF;
  localparam logic [7:0] FLOAT_VAL = 8'hFF;
  // oscillator period of the verify timing figure, in ns, at 25 MHz
  localparam int CLK_NS = 40;
  localparam int OSC_NS = 40;
  localparam int VERIFY_OSC_PERIODS = 48;
  localparam int VERIFY_MAX_NS = VERIFY_OSC_PERIODS * OSC_NS;
  localparam int VERIFY_MAX_CYC =
    (VERIFY_MAX_NS / CLK_NS) < 1 ? 1 : (VERIFY_MAX_NS / CLK_NS);
  // data is shown after a fixed settle time well inside the bound
  localparam int SETTLE_CYC = 4;
  localparam logic [3:0] SETTLE_CNT = 4'h4;
endpackage

// ---- shared/rvl_mem_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface rvl_mem_if;
  logic [12:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [12:0] wr_addr;
  logic [7:0] wr_data;
  modport ctrl (output rd_addr, output wr_en, output wr_addr,
    output wr_data, input rd_data);
  modport mem (input rd_addr, input wr_en, input wr_addr,
    input wr_data, output rd_data);
endinterface
`default_nettype wire

// ---- verilog/rvl_rom.sv ----
`timescale 1ns/1ns
`default_nettype none
module rvl_rom (
  input wire logic clk_sys_i,
  rvl_mem_if.mem mem
);
  logic [7:0] store [0:rvl_pkg::ROM_DEPTH-1];
  logic [7:0] rd_q;
  logic [7:0] next_rd_q;

  initial begin
    for (int i = 0; i < rvl_pkg::ROM_DEPTH; i++) begin
      store[i] = rvl_pkg::ROM_BLANK;
    end
  end

  always_comb begin
    next_rd_q = store[mem.rd_addr];
  end

  always_ff @(posedge clk_sys_i) begin
    if (mem.wr_en) begin
      store[mem.wr_addr] <= mem.wr_data;
    end
    rd_q <= next_rd_q;
  end

  assign mem.rd_data = rd_q;
endmodule
`default_nettype wire

// ---- verilog/rvl_verify_lock.sv ----
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - device returns addressed code byte on port 0
// - two lock levels from two lock bits plus 32-byte encryption table
// - encryption array holds 32 bytes, all ones until programmed
// - five address lines pick the encryption byte
// - verify byte is xnor of encryption byte and code byte
// - both lock bits clear: no locks, verify still encrypted
// - first lock bit blocks external code-table reads of internal rom
// - first lock bit latches external code select at reset
// - both lock bits: level one restrictions plus verify refused
// - data valid within 48 oscillator periods of new address
// - data within 48 periods of enable low, released within 48 after
module rvl_verify_lock (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [7:0] port1_i,
  input wire logic [4:0] port2_i,
  input wire logic verify_enable_n_i,
  input wire logic first_lock_bit_i,
  input wire logic second_lock_bit_i,
  input wire logic external_code_select_i,
  input wire logic code_table_read_instruction_i,
  input wire logic fetch_external_i,
  input wire logic prog_wr_i,
  input wire logic [12:0] prog_addr_i,
  input wire logic [7:0] prog_data_i,
  input wire logic enc_wr_i,
  input wire logic [4:0] enc_addr_i,
  input wire logic [7:0] enc_data_i,
  output logic [7:0] port0_o,
  output logic [7:0] port0_oe_o,
  output logic external_code_select_o,
  output logic code_table_read_allow_o
);
  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  rvl_mem_if mif ();
  rvl_rom u_rom (
    .clk_sys_i(clk_sys_i),
    .mem(mif.mem)
  );

  logic [12:0] vaddr;
  always_comb begin
    vaddr = {port2_i, port1_i};
  end
  assign mif.rd_addr = vaddr;
  assign mif.wr_en = prog_wr_i;
  assign mif.wr_addr = prog_addr_i;
  assign mif.wr_data = prog_data_i;

  // encryption array; few words, so kept as flops
  logic [7:0] enc [0:rvl_pkg::ENC_DEPTH-1];
  logic [7:0] next_enc [0:rvl_pkg::ENC_DEPTH-1];
  always_comb begin
    for (int i = 0; i < rvl_pkg::ENC_DEPTH; i++) begin
      next_enc[i] = enc[i];
    end
    if (enc_wr_i) begin
      next_enc[enc_addr_i] = enc_data_i;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < rvl_pkg::ENC_DEPTH; i++) begin
        enc[i] <= rvl_pkg::ENC_RESET;
      end
    end else begin
      for (int i = 0; i < rvl_pkg::ENC_DEPTH; i++) begin
        enc[i] <= next_enc[i];
      end
    end
  end

  // lock level and latched external select
  logic ecs_latched;
  logic next_ecs_latched;
  logic ecs_caught;
  logic next_ecs_caught;
  always_comb begin
    next_ecs_caught = 1'b1;
    next_ecs_latched = ecs_latched;
    if (!ecs_caught) begin
      next_ecs_latched = external_code_select_i;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ecs_caught <= 1'b0;
      ecs_latched <= 1'b0;
    end else begin
      ecs_caught <= next_ecs_caught;
      ecs_latched <= next_ecs_latched;
    end
  end

  logic lock1;
  logic lock2;
  always_comb begin
    lock1 = first_lock_bit_i;
    lock2 = first_lock_bit_i & second_lock_bit_i;
  end

  logic next_ecs_o;
  logic next_allow;
  always_comb begin
    // a reset-time sample stops late pin changes from opening the rom;
    // the next value is used so the output already holds it one edge later
    next_ecs_o = lock1 ? next_ecs_latched : external_code_select_i;
    next_allow = 1'b1;
    if (lock1 && code_table_read_instruction_i && fetch_external_i) begin
      next_allow = 1'b0;
    end
  end

  // verify sequencer: rom read latency plus a short settle, well under bound
  typedef enum logic [1:0] {RVL_IDLE, RVL_WAIT, RVL_SHOW} rvl_state_t;
  rvl_state_t state;
  rvl_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [12:0] last_addr;
  logic [12:0] next_last_addr;
  logic [7:0] next_p0;
  logic [7:0] next_oe;
  logic [7:0] p0;
  logic [7:0] oe;
  logic [7:0] enc_byte;

  always_comb begin
    enc_byte = enc[last_addr[rvl_pkg::ENC_SEL_W-1:0]];
    next_state = state;
    next_cnt = cnt;
    next_last_addr = last_addr;
    next_p0 = p0;
    next_oe = oe;
    unique case (state)
      RVL_IDLE: begin
        next_oe = 8'h00;
        next_p0 = rvl_pkg::FLOAT_VAL;
        if (!verify_enable_n_i && !lock2) begin
          next_state = RVL_WAIT;
          next_cnt = rvl_pkg::SETTLE_CNT;
          next_last_addr = vaddr;
        end
      end
      RVL_WAIT: begin
        if (verify_enable_n_i || lock2) begin
          // old data may still be held from a previous address
          next_state = RVL_IDLE;
          next_oe = 8'h00;
          next_p0 = rvl_pkg::FLOAT_VAL;
        end else if (vaddr != last_addr) begin
          next_cnt = rvl_pkg::SETTLE_CNT;
          next_last_addr = vaddr;
        end else if (cnt == 4'h0) begin
          next_state = RVL_SHOW;
          next_p0 = ~(enc_byte ^ mif.rd_data);
          next_oe = 8'hFF;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      RVL_SHOW: begin
        if (verify_enable_n_i || lock2) begin
          next_state = RVL_IDLE;
          next_oe = 8'h00;
          next_p0 = rvl_pkg::FLOAT_VAL;
        end else if (vaddr != last_addr) begin
          // old data is held until the new byte settles
          next_state = RVL_WAIT;
          next_cnt = rvl_pkg::SETTLE_CNT;
          next_last_addr = vaddr;
        end
      end
      default: next_state = RVL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= RVL_IDLE;
      cnt <= 4'h0;
      last_addr <= 13'h0000;
      p0 <= 8'hFF;
      oe <= 8'h00;
      external_code_select_o <= 1'b0;
      code_table_read_allow_o <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      last_addr <= next_last_addr;
      p0 <= next_p0;
      oe <= next_oe;
      external_code_select_o <= next_ecs_o;
      code_table_read_allow_o <= next_allow;
    end
  end

  assign port0_o = p0;
  assign port0_oe_o = oe;
endmodule
`default_nettype wire

// ---- tb/rvl_verify_lock_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module rvl_verify_lock_monitor (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [7:0] port1_i,
  input wire logic [4:0] port2_i,
  input wire logic verify_enable_n_i,
  input wire logic first_lock_bit_i,
  input wire logic second_lock_bit_i,
  input wire logic external_code_select_i,
  input wire logic code_table_read_instruction_i,
  input wire logic fetch_external_i,
  input wire logic [7:0] port0_o,
  input wire logic [7:0] port0_oe_o,
  input wire logic external_code_select_o,
  input wire logic code_table_read_allow_o
);
  logic [2:0] up;
  logic lock2;
  logic blk;
  assign lock2 = first_lock_bit_i && second_lock_bit_i;
  assign blk = first_lock_bit_i && code_table_read_instruction_i &&
    fetch_external_i;
  // outputs stay in reset for the synchroniser edges and the select latch
  always_ff @(posedge clk_sys_i or negedge resetn_i)
    if (!resetn_i) up <= 3'h0;
    else if (up != 3'h4) up <= up + 3'h1;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (up != 3'h4);
  sequence s_held;
    (!verify_enable_n_i && !lock2 && $stable({port2_i, port1_i}))[*8];
  endsequence
  chk_verify_valid: assert property ($fell(verify_enable_n_i) && !lock2 ##1 s_held |-> port0_oe_o == 8'hFF)
    else $error("verify data not driven in time");
  chk_release_port: assert property ($rose(verify_enable_n_i) |=> port0_oe_o == 8'h00)
    else $error("port kept driven after enable high");
  chk_lock_refuse: assert property (lock2 [*2] |-> port0_oe_o == 8'h00)
    else $error("verify driven while locked");
  chk_drive_whole: assert property (port0_oe_o == 8'h00 || port0_oe_o == 8'hFF)
    else $error("partial byte drive");
  chk_float_high: assert property (port0_oe_o == 8'h00 |-> port0_o == 8'hFF)
    else $error("undriven port not high");
  chk_table_block: assert property (blk |=> !code_table_read_allow_o)
    else $error("external table read not blocked");
  chk_table_allow: assert property (!blk |=> code_table_read_allow_o)
    else $error("table read blocked without cause");
  chk_select_follow: assert property (!first_lock_bit_i |=> external_code_select_o == $past(external_code_select_i))
    else $error("select does not follow pin");
  chk_select_latch: assert property (first_lock_bit_i [*3] |-> $stable(external_code_select_o))
    else $error("latched select changed");
endmodule
bind rvl_verify_lock rvl_verify_lock_monitor rvl_verify_lock_monitor_inst (.*);
`default_nettype wire

// ---- tb/rvl_tester.sv ----
`timescale 1ns/1ns
`default_nettype none
module rvl_tester (
  input wire logic [7:0] port0_o,
  input wire logic [7:0] port0_oe_o,
  output logic [7:0] bus_o
);
  // released bits read high through the tester's pull-ups
  assign bus_o = (port0_o & port0_oe_o) | ~port0_oe_o;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct {logic [12:0] a; logic [7:0] e, r, x;} rvl_row_t;
  logic clk_sys_i = 1'b0;
  logic rst_n, ven_n, lb1, lb2, ecs, ins, fx, pw, ew, ecs_o, allow;
  logic [7:0] pd, ed, p0, oe, bus;
  logic [4:0] ea;
  logic [12:0] pa, adr;
  int error_cnt = 0;
  int checked = 0;
  // unprogrammed slot 0 first, then slot 31, then a blank code byte exposing its key;
  // the blank byte is kept on purpose to show why images avoid it
  rvl_row_t rows[4] = '{'{13'h0000, 8'hFF, 8'h5A, 8'h5A},
    '{13'h1FFF, 8'h0F, 8'h3C, 8'hCC}, '{13'h0123, 8'hA5, 8'hFF, 8'hA5},
    '{13'h1043, 8'hA5, 8'h00, 8'h5A}};
  always #20 clk_sys_i = ~clk_sys_i;
  rvl_verify_lock rvl_verify_lock_inst (.clk_sys_i(clk_sys_i),
    .resetn_i(rst_n), .port1_i(adr[7:0]), .port2_i(adr[12:8]),
    .verify_enable_n_i(ven_n), .first_lock_bit_i(lb1),
    .second_lock_bit_i(lb2), .external_code_select_i(ecs),
    .code_table_read_instruction_i(ins), .fetch_external_i(fx),
    .prog_wr_i(pw), .prog_addr_i(pa), .prog_data_i(pd), .enc_wr_i(ew),
    .enc_addr_i(ea), .enc_data_i(ed), .port0_o(p0), .port0_oe_o(oe),
    .external_code_select_o(ecs_o), .code_table_read_allow_o(allow));
  rvl_tester rvl_tester_inst (.port0_o(p0), .port0_oe_o(oe), .bus_o(bus));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic rst();
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
    cyc(3);
  endtask
  initial begin
    {ven_n, lb1, lb2, ecs, ins, fx, pw, ew} = 8'h80;
    {adr, pa, pd, ea, ed} = '0;
    rst();
    foreach (rows[i]) begin
      {pw, pa, pd, ea, ed} = {1'b1, rows[i].a, rows[i].r, rows[i].a[4:0], rows[i].e};
      ew = (rows[i].e != 8'hFF);
      cyc(1);
      {pw, ew} = 2'b00;
    end
    foreach (rows[i]) begin
      adr = rows[i].a;
      ven_n = 1'b0;
      cyc(rvl_pkg::VERIFY_MAX_CYC);
      chk(bus, rows[i].x);
    end
    ven_n = 1'b1;
    cyc(48);
    chk(bus, 8'hFF);
    {lb1, lb2, ven_n} = 3'b110;
    cyc(48);
    chk(oe, 8'h00);
    {lb2, ven_n, ins, fx} = 4'b0111;
    cyc(2);
    chk({7'h00, allow}, 8'h00);
    fx = 1'b0;
    cyc(2);
    chk({7'h00, allow}, 8'h01);
    {ins, ecs} = 2'b01;
    rst();
    chk({7'h00, ecs_o}, 8'h01);
    ecs = 1'b0;
    cyc(3);
    chk({7'h00, ecs_o}, 8'h01);
    close_out();
  end
  initial begin
    #(40 * 5000);
    error_cnt++;
    close_out();
  end
endmodule
`default_nettype wire
